/* File: core/sdrb_pkg.sv */
// shared constants for the burst sram port
package sdrb_pkg;
    localparam int          CLK_MHZ    = 100;
    localparam int          DLL_MIN_MHZ = 120;
    localparam int          STOP_NS    = 30;
    localparam int          STOP_CYC   = (STOP_NS * CLK_MHZ + 999) / 1000;
    // oversampled pins cannot resolve the tracking band; a legal level may outlast one stop time
    localparam int          SLOW_CYC   = 4 * STOP_CYC;
    localparam logic [10:0] LOCK_CYC   = 11'h400;
    localparam int          ADDR_W     = 4;
    localparam int          DATA_W     = 36;
    localparam int          DEPTH      = 2 << ADDR_W;
    // packed pin vector layout, low bit first
    localparam int          P_NMASK    = 0;
    localparam int          P_BMASK    = 2;
    localparam int          P_D        = 6;
    localparam int          P_ADDR     = 42;
    localparam int          P_DIR      = 46;
    localparam int          P_LOAD_N   = 47;
    localparam int          P_CB       = 48;
    localparam int          P_C        = 49;
    localparam int          P_KB       = 50;
    localparam int          P_K        = 51;
    localparam int          PIN_W      = 52;
    localparam logic [1:0]  STRAP_WAIT = 2'h3;
    typedef enum logic [1:0] {SDRB_X8, SDRB_X9, SDRB_X18, SDRB_X36} sdrb_width_t;
endpackage : sdrb_pkg

/* File: core/sdrb_port.sv */
// burst sram port: dll lock model, write capture with lane masks, read launch
// Functional notes
// - delay loop tracks input clocks from 120 MHz up to rated maximum; model drops lock after SLOW_CYC clk with no k or kb rise, or when bypass is low.
// - with bypass high, lock reported after 1024 stable input clock cycles.
// - slowing or stopping input clocks resets the loop; it relocks afterwards.
// - bypass pin low disables the delay loop entirely.
// - write: load low, dir low at k; words at next k, then kb.
// - read: word0 on cb rise in t+1, word1 on c rise in t+2.
// - burst uses latched address then next internal location.
// - write data on both input phases; read data on c/cb or k/kb.
// - after power up outputs high impedance until a read.
// - lane masks may differ between the two words of one write.
// - x8: nibble mask bit0 stores [3:0], bit1 stores [7:4].
// - x18: byte mask bit0 stores [8:0], bit1 stores [17:9].
// - x9: single byte mask low stores all nine bits.
// - x36: mask bits 0..3 enable the four nine-bit lanes.
// - all mask bits high writes nothing for that word.
module sdrb_port (
    input  wire logic                         clk_i,
    input  wire logic                         resetn_i,
    input  wire logic                         k_i,
    input  wire logic                         k_n_i,
    input  wire logic                         c_i,
    input  wire logic                         c_n_i,
    input  wire logic                         load_strobe_n_i,
    input  wire logic                         dir_read_i,
    input  wire logic [sdrb_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [sdrb_pkg::DATA_W-1:0]  d_i,
    input  wire logic [3:0]                   byte_lane_mask_n_i,
    input  wire logic [1:0]                   nibble_lane_mask_n_i,
    input  wire logic                         loop_bypass_n_i,
    input  wire sdrb_pkg::sdrb_width_t        width_i,
    output logic      [sdrb_pkg::DATA_W-1:0]  q_o,
    output logic                              q_oe_o,
    output logic                              dll_lock_o,
    output logic                              single_clk_o
);

    typedef struct packed {
        logic [sdrb_pkg::PIN_W-1:0]                      sy1;
        logic [sdrb_pkg::PIN_W-1:0]                      sy2;
        logic [sdrb_pkg::PIN_W-1:0]                      sy3;
        logic [3:0]                                      clkf;
        logic [1:0]                                      st_cnt;
        logic                                            single;
        logic [3:0]                                      gap;
        logic [10:0]                                     lock_cnt;
        logic                                            locked;
        logic                                            wr_p0;
        logic                                            wr_p1;
        logic [sdrb_pkg::ADDR_W-1:0]                     wr_addr;
        logic [sdrb_pkg::ADDR_W-1:0]                     wr_baddr;
        logic                                            rd_p0;
        logic                                            rd_rdy;
        logic                                            rd_w1;
        logic [sdrb_pkg::ADDR_W-1:0]                     rd_addr;
        logic [sdrb_pkg::ADDR_W-1:0]                     rd_laddr;
        logic [sdrb_pkg::DATA_W-1:0]                     q;
        logic                                            oe;
        logic [sdrb_pkg::DEPTH-1:0][sdrb_pkg::DATA_W-1:0] mem;
    } sdrb_state_t;

    sdrb_state_t st_r;
    sdrb_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // lane enables per width, mask active low
    function automatic logic [sdrb_pkg::DATA_W-1:0] sdrb_lanes(
        input sdrb_pkg::sdrb_width_t w,
        input logic [3:0]            bm,
        input logic [1:0]            nm);
        logic [sdrb_pkg::DATA_W-1:0] en;
        en = '0;
        unique case (w)
            sdrb_pkg::SDRB_X8: begin
                en[3:0] = {4{~nm[0]}};
                en[7:4] = {4{~nm[1]}};
            end
            sdrb_pkg::SDRB_X9: begin
                en[8:0] = {9{~bm[0]}};
            end
            sdrb_pkg::SDRB_X18: begin
                en[8:0]  = {9{~bm[0]}};
                en[17:9] = {9{~bm[1]}};
            end
            sdrb_pkg::SDRB_X36: begin
                for (int i = 0; i < 4; i++) begin
                    en[i*9 +: 9] = {9{~bm[i]}};
                end
            end
        endcase
        return en;
    endfunction : sdrb_lanes

    ////////////////////////////////////////////////////////////////////////////
    logic [sdrb_pkg::PIN_W-1:0]  pins;
    logic [3:0]                  clk_lvl;
    logic [3:0]                  agree;
    logic [3:0]                  rise;
    logic                        k_up;
    logic                        kb_up;
    logic                        c_up;
    logic                        cb_up;
    logic                        slow;
    logic [sdrb_pkg::DATA_W-1:0] lane;
    logic [sdrb_pkg::DATA_W-1:0] din;

    assign pins = {k_i, k_n_i, c_i, c_n_i, load_strobe_n_i, dir_read_i, addr_i, d_i,
                   byte_lane_mask_n_i, nibble_lane_mask_n_i};
    assign clk_lvl = st_r.sy3[sdrb_pkg::P_CB +: 4];
    assign agree   = ~(st_r.sy2[sdrb_pkg::P_CB +: 4] ^ clk_lvl);
    assign rise    = agree & clk_lvl & ~st_r.clkf;
    assign k_up    = rise[3];
    assign kb_up   = rise[2];
    // single clock mode launches read data from the input clock pair
    assign c_up    = st_r.single ? rise[3] : rise[1];
    assign cb_up   = st_r.single ? rise[2] : rise[0];
    // no rise on either input phase for the slow time; a longer held level drops lock
    assign slow    = st_r.gap >= 4'(sdrb_pkg::SLOW_CYC);
    assign din     = st_r.sy3[sdrb_pkg::P_D +: sdrb_pkg::DATA_W];
    assign lane    = sdrb_lanes(width_i, st_r.sy3[sdrb_pkg::P_BMASK +: 4],
                                st_r.sy3[sdrb_pkg::P_NMASK +: 2]);

    always_comb begin
        st_nxt      = st_r;
        // only the second and third stages feed the filter
        st_nxt.sy1  = pins;
        st_nxt.sy2  = st_r.sy1;
        st_nxt.sy3  = st_r.sy2;
        st_nxt.clkf = (st_r.clkf & ~agree) | (clk_lvl & agree);

        // strap caught once the synchroniser has filled
        if (st_r.st_cnt != sdrb_pkg::STRAP_WAIT) begin
            st_nxt.st_cnt = st_r.st_cnt + 2'h1;
            if (st_r.st_cnt == sdrb_pkg::STRAP_WAIT - 2'h1) begin
                st_nxt.single = st_r.sy2[sdrb_pkg::P_C] & st_r.sy2[sdrb_pkg::P_CB];
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // delay loop lock model
        if (k_up || kb_up) begin
            st_nxt.gap = '0;
        end else if (!slow) begin
            st_nxt.gap = st_r.gap + 4'h1;
        end
        if (!loop_bypass_n_i) begin
            st_nxt.locked   = 1'b0;
            st_nxt.lock_cnt = '0;
        end else if (slow) begin
            st_nxt.locked   = 1'b0;
            st_nxt.lock_cnt = '0;
        end else if (k_up && !st_r.locked) begin
            st_nxt.lock_cnt = st_r.lock_cnt + 11'h1;
            st_nxt.locked   = (st_r.lock_cnt + 11'h1) == sdrb_pkg::LOCK_CYC;
        end

        ////////////////////////////////////////////////////////////////////////
        // write path; no edges while stopped, so everything simply holds
        if (k_up) begin
            st_nxt.wr_p1 = 1'b0;
            if (st_r.wr_p0) begin
                for (int b = 0; b < sdrb_pkg::DATA_W; b++) begin
                    if (lane[b]) begin
                        st_nxt.mem[{st_r.wr_addr, 1'b0}][b] = din[b];
                    end
                end
                st_nxt.wr_p1    = 1'b1;
                st_nxt.wr_baddr = st_r.wr_addr;
            end
            st_nxt.wr_p0 = 1'b0;
            st_nxt.rd_p0 = 1'b0;
            st_nxt.rd_rdy = st_r.rd_p0;
            st_nxt.rd_laddr = st_r.rd_addr;
            if (!st_r.sy3[sdrb_pkg::P_LOAD_N]) begin
                if (st_r.sy3[sdrb_pkg::P_DIR]) begin
                    st_nxt.rd_p0   = 1'b1;
                    st_nxt.rd_addr = st_r.sy3[sdrb_pkg::P_ADDR +: sdrb_pkg::ADDR_W];
                end else begin
                    st_nxt.wr_p0   = 1'b1;
                    st_nxt.wr_addr = st_r.sy3[sdrb_pkg::P_ADDR +: sdrb_pkg::ADDR_W];
                end
            end
        end
        if (kb_up && st_r.wr_p1 && !k_up) begin
            // masks sampled again with the second word
            for (int b = 0; b < sdrb_pkg::DATA_W; b++) begin
                if (lane[b]) begin
                    st_nxt.mem[{st_r.wr_baddr, 1'b1}][b] = din[b];
                end
            end
            st_nxt.wr_p1 = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        // read launch; c handled before cb so a same-sample pair keeps order
        if (c_up) begin
            if (st_r.rd_w1) begin
                st_nxt.q     = st_r.mem[{st_r.rd_laddr, 1'b1}];
                st_nxt.rd_w1 = 1'b0;
            end else begin
                st_nxt.oe = 1'b0;
            end
        end
        if (cb_up && st_nxt.rd_rdy) begin
            st_nxt.q      = st_r.mem[{st_nxt.rd_laddr, 1'b0}];
            st_nxt.oe     = 1'b1;
            st_nxt.rd_w1  = 1'b1;
            st_nxt.rd_rdy = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_o          = st_r.q;
    assign q_oe_o       = st_r.oe;
    assign dll_lock_o   = st_r.locked;
    assign single_clk_o = st_r.single;

endmodule : sdrb_port

/* File: tb/sdrb_ctrl_model.sv */
// controller-side model: input and output clocks, command, write data and masks
module sdrb_ctrl_model (
    input  wire logic        clk_i,
    input  wire logic [35:0] q_i,
    input  wire logic        q_oe_i,
    output logic             k_o = 1'b0,
    output logic             kb_o = 1'b1,
    output logic             c_o = 1'b0,
    output logic             cb_o = 1'b1,
    output logic             ld_n_o = 1'b1,
    output logic             dir_o = 1'b0,
    output logic [3:0]       addr_o = 4'h0,
    output logic [35:0]      d_o = 36'h0,
    output logic [3:0]       bm_o = 4'hf,
    output logic [1:0]       nm_o = 2'h3
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [36:0] qa;
    logic [36:0] qb;
    ////////////////////////////////////////////////////////////
    // one k period; pins settle 4 clk before each rise and hold 6 after, past the input filter
    task automatic kcyc(input logic [5:0] cmd, input logic [41:0] wk, input logic [41:0] wkb);
        {ld_n_o, dir_o, addr_o} <= cmd;
        {d_o, bm_o, nm_o} <= wk;
        repeat (4) @(posedge clk_i);
        {k_o, kb_o, c_o, cb_o} <= 4'ha;
        repeat (6) @(posedge clk_i);
        qa = {q_oe_i, q_i};
        {d_o, bm_o, nm_o} <= wkb;
        repeat (4) @(posedge clk_i);
        {k_o, kb_o, c_o, cb_o} <= 4'h5;
        repeat (6) @(posedge clk_i);
        qb = {q_oe_i, q_i};
    endtask : kcyc
endmodule : sdrb_ctrl_model

/* File: tb/sdrb_port_properties.sv */
// pin-level checks on the burst sram port
module sdrb_port_props (
    input wire logic                        clk_i,
    input wire logic                        resetn_i,
    input wire logic                        k_i,
    input wire logic                        k_n_i,
    input wire logic                        c_i,
    input wire logic                        c_n_i,
    input wire logic                        load_strobe_n_i,
    input wire logic                        dir_read_i,
    input wire logic                        loop_bypass_n_i,
    input wire logic [sdrb_pkg::DATA_W-1:0] q_o,
    input wire logic                        q_oe_o,
    input wire logic                        dll_lock_o,
    input wire logic                        single_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // 1024 rises at the fastest legal k period of 6 clk
    localparam int LOCK_MIN = 6144;
    // slow time plus pin filter delay and margin
    localparam int STILL_LOCK = sdrb_pkg::SLOW_CYC + 6;
    logic [15:0] age_r;
    logic [7:0]  still_r;
    logic [6:0]  idle_r;
    logic        rd_r;
    default clocking cbk @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence clk_still;
        ($stable(k_i) && $stable(k_n_i) && $stable(c_i) && $stable(c_n_i)) [*8];
    endsequence
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            age_r  <= 16'h0;
            still_r <= 8'h0;
            idle_r <= 7'h0;
            rd_r   <= 1'b0;
        end else begin
            age_r  <= age_r + 16'(age_r != 16'hffff);
            still_r <= ($stable(k_i) && $stable(k_n_i) && $stable(c_i) && $stable(c_n_i)) ?
                       still_r + 8'(still_r != 8'hff) : 8'h0;
            idle_r <= load_strobe_n_i ? idle_r + 7'(idle_r != 7'h7f) : 7'h0;
            rd_r   <= rd_r | (!load_strobe_n_i && dir_read_i && $rose(k_i));
        end
    end
    ////////////////////////////////////////////////////////////
    a_bypass_no_lock: assert property (!loop_bypass_n_i |=> !dll_lock_o) else $error("lock while bypassed");
    a_stop_drops_lock: assert property (still_r >= STILL_LOCK |-> !dll_lock_o)
        else $error("lock kept, clocks still");
    a_stop_holds_q: assert property (clk_still |=> $stable(q_o) && $stable(q_oe_o))
        else $error("outputs moved, clocks still");
    a_lock_too_early: assert property ($rose(dll_lock_o) |-> loop_bypass_n_i && age_r >= LOCK_MIN)
        else $error("lock came too early");
    a_oe_after_read: assert property ($rose(q_oe_o) |-> rd_r) else $error("drive with no read");
    a_strap_fixed: assert property (age_r >= 16'h8 |=> $stable(single_clk_o)) else $error("strap moved");
    a_nop_no_drive: assert property (idle_r >= 7'h3c |-> !q_oe_o) else $error("drive during idle");
    a_nop_q_hold: assert property (idle_r >= 7'h3c |=> $stable(q_o)) else $error("data moved in idle");
endmodule : sdrb_port_props
bind sdrb_port sdrb_port_props chk_u (.*);

/* File: tb/tb_sdrb_port.sv */
// self-checking bench for the burst sram port
module tb_sdrb_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic                        clk_i = 1'b0;
    logic                        resetn_i = 1'b0;
    logic                        k_i, k_n_i, c_i, c_n_i, load_strobe_n_i, dir_read_i;
    logic [sdrb_pkg::ADDR_W-1:0] addr_i;
    logic [35:0]                 d_i, q_o;
    logic [3:0]                  byte_lane_mask_n_i;
    logic [1:0]                  nibble_lane_mask_n_i;
    logic                        loop_bypass_n_i = 1'b1;
    sdrb_pkg::sdrb_width_t       width_i = sdrb_pkg::SDRB_X36;
    logic                        q_oe_o, dll_lock_o, single_clk_o;
    int                          n_errors = 0;
    int                          checks = 0;
    always #5 clk_i = ~clk_i;
    sdrb_port dut_u (.*);
    sdrb_ctrl_model ctl_u (.clk_i(clk_i), .q_i(q_o), .q_oe_i(q_oe_o), .k_o(k_i), .kb_o(k_n_i), .c_o(c_i),
        .cb_o(c_n_i), .ld_n_o(load_strobe_n_i), .dir_o(dir_read_i), .addr_o(addr_i), .d_o(d_i),
        .bm_o(byte_lane_mask_n_i), .nm_o(nibble_lane_mask_n_i));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        if (n_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // stored lanes per width, masks active low
    function automatic logic [35:0] lanes(input int w, input logic [3:0] bm, input logic [1:0] nm);
        case (w)
            0: return {28'h0, {4{~nm[1]}}, {4{~nm[0]}}};
            1: return {27'h0, {9{~bm[0]}}};
            2: return {18'h0, {9{~bm[1]}}, {9{~bm[0]}}};
            default: return {{9{~bm[3]}}, {9{~bm[2]}}, {9{~bm[1]}}, {9{~bm[0]}}};
        endcase
    endfunction : lanes
    task automatic t_lanes(input int w, input logic s);
        logic [35:0] all;
        all = lanes(w, 4'h0, 2'h0);
        resetn_i <= 1'b0;
        width_i <= sdrb_pkg::sdrb_width_t'(w);
        {ctl_u.c_o, ctl_u.cb_o} <= {s, 1'b1};
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        ctl_u.kcyc(6'h03, {36'h0, 6'h3f}, {36'h0, 6'h3f});
        ctl_u.kcyc(6'h03, {{36{1'b1}}, 6'h00}, {{36{1'b1}}, 6'h00});
        ctl_u.kcyc(6'h13, {36'h0, 6'h2a}, {36'h0, 6'h15});
        ctl_u.kcyc(6'h3f, {36'h5a5a5a5a5, 6'h3f}, {36'ha5a5a5a5a, 6'h3f});
        chk("word0", ctl_u.qb[35:0] & all, ~lanes(w, 4'ha, 2'h2) & all);
        chk("oe0", {35'h0, ctl_u.qb[36]}, 36'h1);
        ctl_u.kcyc(6'h3f, {36'h0, 6'h3f}, {36'h0, 6'h3f});
        chk("word1", ctl_u.qa[35:0] & all, ~lanes(w, 4'h5, 2'h1) & all);
        ctl_u.kcyc(6'h3f, {36'h0, 6'h3f}, {36'h0, 6'h3f});
        chk("oe idle", {34'h0, ctl_u.qa[36], ctl_u.qb[36]}, 36'h0);
        chk("strap", {35'h0, single_clk_o}, {35'h0, s});
    endtask : t_lanes
    // first rise after a stop only restarts the loop, so 1024 stable cycles end on rise 1025
    task automatic t_lock();
        repeat (20) @(posedge clk_i);
        repeat (1024) ctl_u.kcyc(6'h3f, {36'h0, 6'h3f}, {36'h0, 6'h3f});
        chk("lock early", {35'h0, dll_lock_o}, 36'h0);
        ctl_u.kcyc(6'h3f, {36'h0, 6'h3f}, {36'h0, 6'h3f});
        chk("lock", {35'h0, dll_lock_o}, 36'h1);
    endtask : t_lock
    // clocks still for 400 ns, well beyond 30 ns, with a read pattern on the pins
    task automatic t_stop();
        ctl_u.ld_n_o <= 1'b0;
        ctl_u.dir_o <= 1'b1;
        {ctl_u.k_o, ctl_u.kb_o, ctl_u.c_o, ctl_u.cb_o} <= 4'h3;
        repeat (40) @(posedge clk_i);
        chk("stop q", q_o, ~lanes(3, 4'h5, 2'h1));
        chk("stop st", {34'h0, q_oe_o, dll_lock_o}, 36'h0);
        ctl_u.ld_n_o <= 1'b1;
    endtask : t_stop
    // bypass low must drop a lock that is held
    task automatic t_bypass();
        loop_bypass_n_i <= 1'b0;
        repeat (3) ctl_u.kcyc(6'h3f, {36'h0, 6'h3f}, {36'h0, 6'h3f});
        chk("bypass", {35'h0, dll_lock_o}, 36'h0);
        loop_bypass_n_i <= 1'b1;
    endtask : t_bypass
    initial begin
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk("idle", {33'h0, q_oe_o, dll_lock_o, single_clk_o}, 36'h0);
        @(posedge clk_i);
        for (int w = 0; w < 4; w++) t_lanes(w, 1'b0);
        t_lanes(3, 1'b1);
        t_lock();
        t_stop();
        t_lock();
        t_bypass();
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        n_errors++;
        print_verdict();
    end
endmodule : tb_sdrb_port
